// ### verilog/cts_core.sv
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cts_core (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        wake,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             osc_run,
	output logic      [7:0]  port_a_direction,
	output logic      [7:0]  port_b_direction,
	output logic      [7:0]  port_c_direction
);
	logic [7:0]  work_r, work_nxt;
	logic [7:0]  freg_r, freg_nxt;
	logic [7:0]  status_r, status_nxt;
	logic [7:0]  wdog_r, wdog_nxt;
	logic [7:0]  presc_r, presc_nxt;
	logic [7:0]  dira_r, dira_nxt;
	logic [7:0]  dirb_r, dirb_nxt;
	logic [7:0]  dirc_r, dirc_nxt;
	logic        asleep_r, asleep_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        wake_m_r, wake_s_r;
	logic        wr_go;
	logic [2:0]  op;
	logic        dest;
	logic [7:0]  arg;
	logic [7:0]  alu_res;
	logic        alu_c, alu_dc, alu_z;

	// Wake pin synchroniser
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_m_r <= 1'b0;
			wake_s_r <= 1'b0;
		end else begin
			wake_m_r <= wake;
			wake_s_r <= wake_m_r;
		end
	end

	// Command decode from write data
	assign wr_go = cyc_i && stb_i && we_i && !ack_r;
	assign op    = dat_i[cts_pkg::CMD_OP_LSB +: cts_pkg::CMD_OP_W];
	assign dest  = dat_i[cts_pkg::CMD_DEST_BIT];
	assign arg   = dat_i[cts_pkg::CMD_ARG_LSB +: cts_pkg::CMD_ARG_W];

	cts_alu u_alu (
		.op       (op),
		.work     (work_r),
		.fval     (freg_r),
		.lit      (arg),
		.carry_in (status_r[cts_pkg::ST_C]),
		.result   (alu_res),
		.c_out    (alu_c),
		.dc_out   (alu_dc),
		.z_out    (alu_z)
	);

	// Next state: bus writes and instruction execution
	always_comb begin
		work_nxt   = work_r;
		freg_nxt   = freg_r;
		status_nxt = status_r;
		wdog_nxt   = wdog_r;
		presc_nxt  = presc_r;
		dira_nxt   = dira_r;
		dirb_nxt   = dirb_r;
		dirc_nxt   = dirc_r;
		asleep_nxt = asleep_r;
		ack_nxt    = cyc_i && stb_i && !ack_r;
		dat_nxt    = 32'h0000_0000;
		if (asleep_r && wake_s_r)
			asleep_nxt = 1'b0;
		if (wr_go && sel_i[0] && !asleep_r) begin
			unique case (adr_i)
				cts_pkg::ADDR_CMD: begin
					unique case (op)
						3'(cts_pkg::OP_SLEEP): begin
							wdog_nxt   = cts_pkg::WDOG_CLR;
							presc_nxt  = cts_pkg::WDOG_CLR;
							status_nxt[cts_pkg::ST_TIMEOUT]   = 1'b1;
							status_nxt[cts_pkg::ST_POWERDOWN] = 1'b0;
							asleep_nxt = 1'b1;
						end
						3'(cts_pkg::OP_SUB),
						3'(cts_pkg::OP_SUBB): begin
							if (dest)
								freg_nxt = alu_res;
							else
								work_nxt = alu_res;
							status_nxt[cts_pkg::ST_C]  = alu_c;
							status_nxt[cts_pkg::ST_DIGIT_CARRY] = alu_dc;
							status_nxt[cts_pkg::ST_Z]  = alu_z;
						end
						3'(cts_pkg::OP_SWAP): begin
							if (dest)
								freg_nxt = alu_res;
							else
								work_nxt = alu_res;
						end
						3'(cts_pkg::OP_XORL): begin
							work_nxt = alu_res;
							status_nxt[cts_pkg::ST_Z] = alu_z;
						end
						3'(cts_pkg::OP_XORF): begin
							if (dest)
								freg_nxt = alu_res;
							else
								work_nxt = alu_res;
							status_nxt[cts_pkg::ST_Z] = alu_z;
						end
						3'(cts_pkg::OP_DIRLD): begin
							unique case (arg)
								cts_pkg::DIR_SEL_A: dira_nxt = work_r;
								cts_pkg::DIR_SEL_B: dirb_nxt = work_r;
								cts_pkg::DIR_SEL_C: dirc_nxt = work_r;
								default: ;
							endcase
						end
						default: ;
					endcase
				end
				cts_pkg::ADDR_WORK:   work_nxt   = dat_i[7:0];
				cts_pkg::ADDR_FREG:   freg_nxt   = dat_i[7:0];
				cts_pkg::ADDR_STATUS: status_nxt = dat_i[7:0] & 8'h1f;
				cts_pkg::ADDR_WDOG: begin
					wdog_nxt  = dat_i[7:0];
					presc_nxt = dat_i[15:8];
				end
				default: ;
			endcase
		end
		// Read mux; unmapped reads as zero
		if (cyc_i && stb_i && !we_i && !ack_r) begin
			unique case (adr_i)
				cts_pkg::ADDR_WORK:   dat_nxt = {24'h00_0000, work_r};
				cts_pkg::ADDR_FREG:   dat_nxt = {24'h00_0000, freg_r};
				cts_pkg::ADDR_STATUS: dat_nxt = {24'h00_0000, status_r};
				cts_pkg::ADDR_DIR_A:  dat_nxt = {24'h00_0000, dira_r};
				cts_pkg::ADDR_DIR_B:  dat_nxt = {24'h00_0000, dirb_r};
				cts_pkg::ADDR_DIR_C:  dat_nxt = {24'h00_0000, dirc_r};
				cts_pkg::ADDR_WDOG:   dat_nxt = {16'h0000, presc_r, wdog_r};
				cts_pkg::ADDR_CTRL:   dat_nxt = {31'h0000_0000, asleep_r};
				default:              dat_nxt = 32'h0000_0000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			work_r   <= 8'h00;
			freg_r   <= 8'h00;
			status_r <= cts_pkg::STATUS_RST;
			wdog_r   <= cts_pkg::WDOG_CLR;
			presc_r  <= cts_pkg::WDOG_CLR;
			dira_r   <= cts_pkg::DIR_RST;
			dirb_r   <= cts_pkg::DIR_RST;
			dirc_r   <= cts_pkg::DIR_RST;
			asleep_r <= 1'b0;
			ack_r    <= 1'b0;
			dat_r    <= 32'h0000_0000;
		end else begin
			work_r   <= work_nxt;
			freg_r   <= freg_nxt;
			status_r <= status_nxt;
			wdog_r   <= wdog_nxt;
			presc_r  <= presc_nxt;
			dira_r   <= dira_nxt;
			dirb_r   <= dirb_nxt;
			dirc_r   <= dirc_nxt;
			asleep_r <= asleep_nxt;
			ack_r    <= ack_nxt;
			dat_r    <= dat_nxt;
		end
	end

	// Outputs
	assign ack_o            = ack_r;
	assign dat_o            = dat_r;
	assign osc_run          = !asleep_r;
	assign port_a_direction = dira_r;
	assign port_b_direction = dirb_r;
	assign port_c_direction = dirc_r;

	// Checks
	sequence cmd_s(logic [2:0] o);
		wr_go && sel_i[0] && !asleep_r && adr_i == cts_pkg::ADDR_CMD && op == o;
	endsequence

	AST_SLEEP_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SLEEP)) |=> status_r[cts_pkg::ST_TIMEOUT]
		&& !status_r[cts_pkg::ST_POWERDOWN]
		&& wdog_r == 8'h00 && presc_r == 8'h00)
		else $error("sleep flags or watchdog wrong");
	AST_SLEEP_HALT: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SLEEP)) |=> !osc_run && $stable(work_r))
		else $error("oscillator not stopped after sleep");
	// Zero flag follows the byte that landed in the chosen destination
	sequence zero_s;
		status_r[cts_pkg::ST_Z] == (($past(dest) ? freg_r : work_r) == 8'h00);
	endsequence

	// Plain subtract
	AST_SUB_RES: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUB)) ##0 !dest
		|=> work_r == 8'($past(freg_r) - $past(work_r)) && $stable(freg_r))
		else $error("subtract result wrong");
	AST_SUB_DEST: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUB)) ##0 dest
		|=> freg_r == 8'($past(freg_r) - $past(work_r)) && $stable(work_r))
		else $error("subtract to register wrong");
	AST_SUB_C: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUB)) |=> status_r[cts_pkg::ST_C] == ($past(work_r) <= $past(freg_r)))
		else $error("subtract carry wrong");
	AST_SUB_DC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUB)) |=> status_r[cts_pkg::ST_DIGIT_CARRY]
		== ($past(work_r[3:0]) <= $past(freg_r[3:0])))
		else $error("subtract digit carry wrong");
	AST_SUB_Z: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUB)) |=> zero_s)
		else $error("subtract zero flag wrong");

	// Subtract with borrow, borrow being the inverted carry
	AST_SUBB_RES: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUBB)) ##0 dest |=> freg_r == 8'($past(freg_r) - $past(work_r)
		- 8'(!$past(status_r[cts_pkg::ST_C]))))
		else $error("borrow subtract result wrong");
	AST_SUBB_WORK: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUBB)) ##0 !dest |=> work_r == 8'($past(freg_r) - $past(work_r)
		- 8'(!$past(status_r[cts_pkg::ST_C]))) && $stable(freg_r))
		else $error("borrow subtract to working wrong");
	AST_SUBB_C: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUBB)) |=> status_r[cts_pkg::ST_C]
		== ({1'b0, $past(work_r)} + 9'(!$past(status_r[cts_pkg::ST_C]))
		<= {1'b0, $past(freg_r)}))
		else $error("borrow subtract carry wrong");
	AST_SUBB_DC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUBB)) |=> status_r[cts_pkg::ST_DIGIT_CARRY]
		== ({1'b0, $past(work_r[3:0])} + 5'(!$past(status_r[cts_pkg::ST_C]))
		<= {1'b0, $past(freg_r[3:0])}))
		else $error("borrow subtract digit carry wrong");
	AST_SUBB_Z: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SUBB)) |=> zero_s)
		else $error("borrow subtract zero flag wrong");

	// Nibble exchange and the two exclusive-OR forms
	AST_SWAP_RES: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SWAP)) ##0 !dest
		|=> work_r == {$past(freg_r[3:0]), $past(freg_r[7:4])} && $stable(freg_r))
		else $error("nibble exchange result wrong");
	AST_SWAP_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_SWAP)) |=> $stable(status_r))
		else $error("swap touched flags");
	AST_XORL_RES: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_XORL)) |=> work_r == ($past(work_r) ^ $past(arg)) && $stable(freg_r))
		else $error("literal xor result wrong");
	AST_XORL_Z: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_XORL)) |=> status_r[cts_pkg::ST_Z] == (work_r == 8'h00)
		&& status_r[1:0] == $past(status_r[1:0]))
		else $error("literal xor flags wrong");
	AST_XORF_RES: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_XORF)) ##0 dest
		|=> freg_r == ($past(work_r) ^ $past(freg_r)) && $stable(work_r))
		else $error("register xor result wrong");
	AST_XORF_Z: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_XORF)) |=> zero_s ##0 $stable(status_r[1:0]))
		else $error("register xor flags wrong");

	// Direction loads
	AST_DIR_A: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_DIRLD)) ##0 arg == cts_pkg::DIR_SEL_A
		|=> port_a_direction == $past(work_r) && $stable(dirb_r) && $stable(dirc_r))
		else $error("direction load a wrong");
	AST_DIR_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_DIRLD)) ##0 arg == cts_pkg::DIR_SEL_B
		|=> port_b_direction == $past(work_r) && $stable(status_r))
		else $error("direction load wrong");
	AST_DIR_C: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_DIRLD)) ##0 arg == cts_pkg::DIR_SEL_C
		|=> port_c_direction == $past(work_r) && $stable(dira_r) && $stable(dirb_r))
		else $error("direction load c wrong");
	AST_DIR_BAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_s(3'(cts_pkg::OP_DIRLD)) ##0 (arg < cts_pkg::DIR_SEL_A || arg > cts_pkg::DIR_SEL_C)
		|=> $stable(dira_r) && $stable(dirb_r) && $stable(dirc_r))
		else $error("bad operand changed direction");

	// Sleep holds the core until the synchronised wake arrives
	AST_ASLEEP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		asleep_r |=> $stable(work_r) && $stable(freg_r) && $stable(status_r) && $stable(dira_r))
		else $error("state changed while asleep");
	AST_WAKE_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		asleep_r && !wake_s_r |=> asleep_r && !osc_run)
		else $error("left sleep without wake");
endmodule

// ### verilog/cts_pkg.sv
package cts_pkg;
	// Wishbone register byte offsets
	localparam logic [7:0] ADDR_CMD    = 8'h00; // Instruction launch
	localparam logic [7:0] ADDR_WORK   = 8'h04; // Working register
	localparam logic [7:0] ADDR_FREG   = 8'h08; // Addressed register operand/result
	localparam logic [7:0] ADDR_STATUS = 8'h0c; // Status flags
	localparam logic [7:0] ADDR_DIR_A  = 8'h10;
	localparam logic [7:0] ADDR_DIR_B  = 8'h14;
	localparam logic [7:0] ADDR_DIR_C  = 8'h18;
	localparam logic [7:0] ADDR_WDOG   = 8'h1c; // Watchdog count and prescaler
	localparam logic [7:0] ADDR_CTRL   = 8'h20; // Sleep state, read only

	// Command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_OP_W     = 3;
	localparam int CMD_DEST_BIT = 3;
	localparam int CMD_ARG_LSB  = 8;
	localparam int CMD_ARG_W    = 8;
	localparam int FADDR_MAX    = 127;

	// Status register bit positions
	localparam int ST_C           = 0;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_Z           = 2;
	localparam int ST_POWERDOWN   = 3;
	localparam int ST_TIMEOUT     = 4;

	// Reset values and direction-load operand codes
	localparam logic [7:0] STATUS_RST = 8'h18; // Time-out and power-down flags set
	localparam logic [7:0] DIR_RST    = 8'hff; // All pins input
	localparam logic [7:0] WDOG_CLR   = 8'h00;
	localparam logic [7:0] DIR_SEL_A  = 8'h05;
	localparam logic [7:0] DIR_SEL_B  = 8'h06;
	localparam logic [7:0] DIR_SEL_C  = 8'h07;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SLEEP,
		OP_SUB,
		OP_SUBB,
		OP_SWAP,
		OP_XORL,
		OP_XORF,
		OP_DIRLD
	} cts_op_t;
endpackage

// ### verilog/cts_alu.sv
`timescale 1ns/1ps
// Combinational result and flag datapath
module cts_alu (
	input  wire logic [2:0] op,
	input  wire logic [7:0] work,
	input  wire logic [7:0] fval,
	input  wire logic [7:0] lit,
	input  wire logic       carry_in,
	output logic      [7:0] result,
	output logic            c_out,
	output logic            dc_out,
	output logic            z_out
);
	logic [8:0] diff;
	logic [4:0] ndiff;
	logic       borrow;

	// Subtract as f + ~W + carry-in, so carry means no borrow
	always_comb begin
		borrow = 1'b0;
		if (op == 3'(cts_pkg::OP_SUBB))
			borrow = ~carry_in;
		diff   = {1'b0, fval} + {1'b0, ~work} + 9'(!borrow);
		ndiff  = {1'b0, fval[3:0]} + {1'b0, ~work[3:0]} + 5'(!borrow);
		result = 8'h00;
		unique case (op)
			3'(cts_pkg::OP_SUB),
			3'(cts_pkg::OP_SUBB): result = diff[7:0];
			3'(cts_pkg::OP_SWAP): result = {fval[3:0], fval[7:4]};
			3'(cts_pkg::OP_XORL): result = work ^ lit;
			3'(cts_pkg::OP_XORF): result = work ^ fval;
			default:              result = 8'h00;
		endcase
		c_out  = diff[8];
		dc_out = ndiff[4];
		z_out  = (result == 8'h00);
	end
endmodule

// ### dv/cts_core_bench.sv
`timescale 1ns/1ps
// Bench for the instruction datapath, reached over the register bus
module cts_core_bench;
	logic        ref_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        wake    = 1'b0;
	logic        cyc_i   = 1'b0;
	logic        stb_i   = 1'b0;
	logic        we_i    = 1'b0;
	logic [7:0]  adr_i   = 8'h00;
	logic [3:0]  sel_i   = 4'h0;
	logic [31:0] dat_i   = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        osc_run;
	logic [7:0]  dir_a;
	logic [7:0]  dir_b;
	logic [7:0]  dir_c;
	logic [31:0] rd;
	logic [59:0] r;
	int          err_total = 0;
	int          n_checks  = 0;
	int          cycles    = 0;
	// Rows: cmd nibble, literal, W, F, status in, then W, F, status expected
	logic [59:0] rows [12] = '{
		60'h2_00_05_10_18_0b_10_19, 60'ha_00_10_10_18_10_00_1f,
		60'h2_00_20_10_1f_f0_10_1a, 60'hb_00_01_10_18_01_0e_19,
		60'h3_00_10_10_19_00_10_1f, 60'h3_00_0f_10_18_00_10_1d,
		60'hc_00_33_a5_1b_33_5a_1b, 60'h4_00_00_3c_04_c3_3c_04,
		60'h5_ff_ff_11_03_00_11_07, 60'h5_5a_0f_11_07_55_11_03,
		60'he_00_aa_aa_1b_aa_00_1f, 60'h6_00_0f_f0_04_ff_f0_00};

	cts_core cts_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .wake(wake), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .osc_run(osc_run), .port_a_direction(dir_a),
		.port_b_direction(dir_b), .port_c_direction(dir_c));

	// Clock and hang guard
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic cycle; request held until ack is sampled high at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge ref_clk);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		wb(1'b0, a, 32'h0, 4'hf);
		check(rd & m, exp);
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			r = rows[i];
			wr(cts_pkg::ADDR_WORK, {24'h0, r[47:40]});
			wr(cts_pkg::ADDR_FREG, {24'h0, r[39:32]});
			wr(cts_pkg::ADDR_STATUS, {24'h0, r[31:24]});
			wr(cts_pkg::ADDR_CMD, {16'h0, r[55:48], 4'h0, r[59:56]});
			rc(cts_pkg::ADDR_WORK, {24'h0, r[23:16]}, 32'hff);
			rc(cts_pkg::ADDR_FREG, {24'h0, r[15:8]}, 32'hff);
			rc(cts_pkg::ADDR_STATUS, {24'h0, r[7:0]}, 32'h1f);
		end
		// Direction loads, operands 4 and 8 fall outside; 4 goes last so a stray write shows
		wr(cts_pkg::ADDR_STATUS, 32'h1b);
		for (int k = 5; k <= 8; k++) begin
			wr(cts_pkg::ADDR_WORK, 32'h40 + k);
			wr(cts_pkg::ADDR_CMD, {16'h0, k[7:0], 8'h07});
		end
		wr(cts_pkg::ADDR_CMD, 32'h0407);
		check({8'h0, dir_a, dir_b, dir_c}, 32'h00454647);
		rc(cts_pkg::ADDR_DIR_B, 32'h46, 32'hff);
		rc(cts_pkg::ADDR_STATUS, 32'h1b, 32'h1f);
		// Sleep, then writes ignored until wake
		wr(cts_pkg::ADDR_STATUS, 32'h07);
		wr(cts_pkg::ADDR_WDOG, 32'h3c5a);
		wr(cts_pkg::ADDR_CMD, 32'h1);
		rc(cts_pkg::ADDR_STATUS, 32'h17, 32'h1f);
		rc(cts_pkg::ADDR_WDOG, 32'h0, 32'hffff);
		check({31'h0, osc_run}, 32'h0);
		rc(cts_pkg::ADDR_CTRL, 32'h1, 32'h1);
		wr(cts_pkg::ADDR_WORK, 32'h77);
		rc(cts_pkg::ADDR_WORK, 32'h48, 32'hff);
		wake <= 1'b1;
		for (int n = 0; n < 20 && osc_run !== 1'b1; n++)
			@(posedge ref_clk);
		wake <= 1'b0;
		check({31'h0, osc_run}, 32'h1);
		// Byte lane off, unmapped read
		wb(1'b1, cts_pkg::ADDR_WORK, 32'h99, 4'he);
		rc(cts_pkg::ADDR_WORK, 32'h48, 32'hff);
		rc(8'h30, 32'h0, 32'hffffffff);
		// Second reset mid-run
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		check({8'h0, dir_a, dir_b, dir_c}, 32'h00ffffff);
		rc(cts_pkg::ADDR_STATUS, {24'h0, cts_pkg::STATUS_RST}, 32'h1f);
		rc(cts_pkg::ADDR_WORK, 32'h0, 32'hff);
		complete_run();
	end
endmodule
